/* rtl/tcq_defs.svh */
`ifndef TCQ_DEFS_SVH
`define TCQ_DEFS_SVH
// Page number width and queue depth
`define TCQ_PAGE_W 3
`define TCQ_DEPTH 2
// Clock period and the least inactive gap between interrupts
`define TCQ_CLK_PERIOD_NS 100
`define TCQ_INT_GAP_NS 200
`define TCQ_GAP_CYC ((`TCQ_INT_GAP_NS + `TCQ_CLK_PERIOD_NS - 1) / `TCQ_CLK_PERIOD_NS)
// Gap counter width
`define TCQ_GAP_W 8
// Reset values
`define TCQ_CHAIN_RST 1'b0
`define TCQ_AVAIL_RST 1'b1
`define TCQ_INHIBIT_RST 1'b1
`endif

/* rtl/tcq_pkg.sv */
package tcq_pkg;
	// Command strobes from the host
	typedef struct packed {
		logic en_tx;
		logic dis_tx;
		logic clr_tx_int;
		logic en_rx;
		logic dis_rx;
		logic clr_rx_int;
		logic [2:0] page;
	} tcq_cmd_s;
	// Events from the protocol engine
	typedef struct packed {
		logic token;
		logic tx_done;
		logic tx_acked;
		logic rx_start;
		logic rx_done;
	} tcq_eng_s;
	// Interrupt gap states
	typedef enum logic [1:0] {
		TCQ_IDLE = 2'b00,
		TCQ_ACTIVE = 2'b01,
		TCQ_GAP = 2'b11
	} tcq_gap_e;
endpackage

/* rtl/tcq_queue.sv */
`timescale 1ns/100ps
`include "tcq_defs.svh"
// Two-deep page queue with completion status double buffer
module tcq_queue
	import tcq_pkg::*;
#(
	parameter int PAGE_W = `TCQ_PAGE_W
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic chain_in,
	input wire logic push_in,
	input wire logic [PAGE_W-1:0] page_in,
	input wire logic cancel_in,
	input wire logic cancel_block_in,
	input wire logic done_in,
	input wire logic ok_in,
	input wire logic clear_in,
	output logic busy_out,
	output logic [1:0] count_out,
	output logic [PAGE_W-1:0] head_page_out,
	output logic event_out,
	output logic ok_out
);
	typedef struct packed {
		logic [1:0] cnt;
		logic [PAGE_W-1:0] p0;
		logic [PAGE_W-1:0] p1;
		logic ev0;
		logic ok0;
		logic ev1;
		logic ok1;
	} q_s;
	q_s st;
	q_s next_st;
	logic limit;

	// Refuse widths the queue cannot serve
	if (PAGE_W < 1) begin
		$error("PAGE_W too small");
	end

	// Queue depth limit: one in plain mode, two when chaining
	assign limit = chain_in ? 1'b1 : 1'b0;

	// Next state of queue and status buffer
	always_comb begin
		next_st = st;
		// Completion retires the head and buffers its result
		if (done_in && st.cnt != 2'h0) begin
			next_st.p0 = st.p1;
			next_st.cnt = st.cnt - 2'h1;
			if (!st.ev0 || (clear_in && !st.ev1)) begin
				next_st.ev0 = 1'b1;
				next_st.ok0 = ok_in;
			end else begin
				next_st.ev1 = 1'b1;
				next_st.ok1 = ok_in;
			end
			if (clear_in && st.ev1) begin
				next_st.ok0 = st.ok1;
				next_st.ok1 = ok_in;
			end
		end else if (clear_in) begin
			next_st.ev0 = st.ev1;
			next_st.ok0 = st.ok1;
			next_st.ev1 = 1'b0;
		end
		// Cancel oldest unless already started
		if (cancel_in && !cancel_block_in && st.cnt != 2'h0 && !done_in) begin
			next_st.p0 = st.p1;
			next_st.cnt = st.cnt - 2'h1;
		end
		// Accept up to two pending, ignore a third
		if (push_in && (st.cnt == 2'h0 || (st.cnt == 2'h1 && limit))) begin
			if (next_st.cnt == 2'h0)
				next_st.p0 = page_in;
			else
				next_st.p1 = page_in;
			next_st.cnt = next_st.cnt + 2'h1;
		end
	end

	// State register
	always_ff @(posedge clk_in) begin
		if (srst_in)
			st <= '0;
		else
			st <= next_st;
	end

	assign busy_out = st.cnt != 2'h0;
	assign count_out = st.cnt;
	assign head_page_out = st.p0;
	assign event_out = st.ev0;
	assign ok_out = st.ok0;
endmodule

/* rtl/tcq_gap.sv */
`timescale 1ns/100ps
`include "tcq_defs.svh"
// Interrupt line with enforced inactive gap between edges
module tcq_gap
	import tcq_pkg::*;
#(
	parameter int GAP_W = `TCQ_GAP_W
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic req_in,
	input wire logic [GAP_W-1:0] gap_cyc_in,
	output logic irq_out
);
	typedef struct packed {
		tcq_gap_e state;
		logic [GAP_W-1:0] cnt;
		logic irq;
	} g_s;
	g_s st;
	g_s next_st;

	// Refuse counter widths below two bits
	if (GAP_W < 2) begin
		$error("GAP_W too small");
	end

	// Assert while requested, then hold low for the gap
	always_comb begin
		next_st = st;
		unique case (st.state)
			TCQ_IDLE: begin
				if (req_in) begin
					next_st.state = TCQ_ACTIVE;
					next_st.irq = 1'b1;
				end
			end
			TCQ_ACTIVE: begin
				if (!req_in) begin
					next_st.state = TCQ_GAP;
					next_st.irq = 1'b0;
					next_st.cnt = gap_cyc_in;
				end
			end
			TCQ_GAP: begin
				if (st.cnt <= GAP_W'(1))
					next_st.state = TCQ_IDLE;
				else
					next_st.cnt = st.cnt - GAP_W'(1);
			end
			default: begin
				next_st.state = TCQ_IDLE;
				next_st.irq = 1'b0;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_in) begin
		if (srst_in)
			st <= '{state: TCQ_IDLE, cnt: '0, irq: 1'b0};
		else
			st <= next_st;
	end

	assign irq_out = st.irq;
endmodule

/* rtl/tcq_top.sv */
`timescale 1ns/100ps
`include "tcq_defs.svh"
// Operation
// - Power up unchained; chaining when enable set
// - Two transmit, two receive pending, any order
// - Live available and inhibit flags kept separately
// - First transmit clears available and ack flags
// - Second transmit stored with page anytime
// - Transmit completion sets done event, interrupts
// - Only clear-transmit command clears done event
// - Transmit status double-buffered until cleared
// - Interrupt held until acked; next waits
// - At least 200 ns inactive between interrupts
// - Ack flag buffered with done, no interrupt
// - Stored transmit starts at next token
// - After clear, second result shown, interrupts again
// - Available mask gates only transmit done event
// - Done event set by transmission only, not reset
// - Each disable-transmit cancels oldest queued
// - Two consecutive enable-receive commands accepted
// - Reception sets done, inhibit, and interrupts
// - Receive done cleared only by clear command
// - Second queued receive takes next packet
// - Inhibit mask gates only receive done
// - Disable-receive cancels oldest unless begun
module tcq_top
	import tcq_pkg::*;
#(
	parameter int PAGE_W = `TCQ_PAGE_W,
	parameter int GAP_W = `TCQ_GAP_W
) (
	input wire logic CLK_SYS_IN,
	input wire logic SRST_IN,
	input wire logic CHAIN_EN_IN,
	input wire logic [1:0] CLOCK_MULT_SETTING_IN,
	input wire logic TX_AVAIL_MASK_IN,
	input wire logic RX_INHIBIT_MASK_IN,
	input wire tcq_cmd_s CMD_IN,
	input wire tcq_eng_s ENG_IN,
	output logic CHAIN_MODE_OUT,
	output logic TRANSMITTER_AVAILABLE_FLAG_OUT,
	output logic RECEIVER_INHIBIT_FLAG_OUT,
	output logic TX_DONE_EVENT_OUT,
	output logic TX_ACK_FLAG_OUT,
	output logic RX_DONE_EVENT_OUT,
	output logic TX_START_OUT,
	output logic [PAGE_W-1:0] TX_PAGE_OUT,
	output logic RX_ARMED_OUT,
	output logic [PAGE_W-1:0] RX_PAGE_OUT,
	output logic [1:0] TX_PENDING_OUT,
	output logic [1:0] RX_PENDING_OUT,
	output logic IRQ_OUT
);
	localparam int GAP_CYC = `TCQ_GAP_CYC;

	// Whole top-level state
	typedef struct packed {
		logic chain;
		logic avail;
		logic inhibit;
		logic tx_active;
		logic rx_active;
		logic tx_start;
		logic ack_live;
		logic [PAGE_W-1:0] tx_page;
		logic [PAGE_W-1:0] rx_page;
		logic rx_armed;
		logic [1:0] txn;
		logic [1:0] rxn;
		logic tx_ev;
		logic tx_ok;
		logic rx_ev;
		logic ack;
		logic irq;
	} top_s;
	top_s st;
	top_s next_st;

	logic tx_busy, rx_busy;
	logic [1:0] tx_cnt, rx_cnt;
	logic [PAGE_W-1:0] tx_head, rx_head;
	logic tx_event, tx_ok, rx_event;
	logic tx_req, rx_req, irq_req;
	logic [GAP_W-1:0] gap_cyc;
	logic irq_line;
	logic tx_done_q, rx_done_q;

	// Page width is fixed by the command struct
	if (PAGE_W != `TCQ_PAGE_W) begin
		$error("PAGE_W must match CMD_IN page");
	end
	// Largest multiplier shifts the gap by three places
	if (GAP_CYC * 8 >= (1 << GAP_W)) begin
		$error("GAP_W too small");
	end

	// Completions only count while an operation is live
	assign tx_done_q = ENG_IN.tx_done && st.tx_active;
	assign rx_done_q = ENG_IN.rx_done && st.rx_active;

	// Transmit queue: completion from engine only
	tcq_queue #(
		.PAGE_W(PAGE_W)
	) u_txq (
		.clk_in(CLK_SYS_IN),
		.srst_in(SRST_IN),
		.chain_in(st.chain),
		.push_in(CMD_IN.en_tx),
		.page_in(CMD_IN.page),
		.cancel_in(CMD_IN.dis_tx),
		.cancel_block_in(1'b0),
		.done_in(tx_done_q),
		.ok_in(ENG_IN.tx_acked),
		.clear_in(CMD_IN.clr_tx_int),
		.busy_out(tx_busy),
		.count_out(tx_cnt),
		.head_page_out(tx_head),
		.event_out(tx_event),
		.ok_out(tx_ok)
	);

	// Receive queue: cancel blocked once reception began
	tcq_queue #(
		.PAGE_W(PAGE_W)
	) u_rxq (
		.clk_in(CLK_SYS_IN),
		.srst_in(SRST_IN),
		.chain_in(st.chain),
		.push_in(CMD_IN.en_rx),
		.page_in(CMD_IN.page),
		.cancel_in(CMD_IN.dis_rx),
		.cancel_block_in(st.rx_active),
		.done_in(rx_done_q),
		.ok_in(1'b1),
		.clear_in(CMD_IN.clr_rx_int),
		.busy_out(rx_busy),
		.count_out(rx_cnt),
		.head_page_out(rx_head),
		.event_out(rx_event),
		.ok_out()
	);

	// Masks gate only the done events
	assign tx_req = tx_event && TX_AVAIL_MASK_IN;
	assign rx_req = rx_event && RX_INHIBIT_MASK_IN;
	assign irq_req = tx_req || rx_req;

	// Gap scales with the clock multiplier
	assign gap_cyc = GAP_W'(GAP_CYC) << CLOCK_MULT_SETTING_IN;

	// Interrupt line with inactive gap
	tcq_gap #(
		.GAP_W(GAP_W)
	) u_gap (
		.clk_in(CLK_SYS_IN),
		.srst_in(SRST_IN),
		.req_in((tx_req && !CMD_IN.clr_tx_int) ||
			(rx_req && !CMD_IN.clr_rx_int)),
		.gap_cyc_in(gap_cyc),
		.irq_out(irq_line)
	);

	// Next top-level state
	always_comb begin
		next_st = st;
		next_st.chain = CHAIN_EN_IN;
		next_st.tx_start = 1'b0;
		// Start head transmission at token
		if (tx_busy && !st.tx_active && ENG_IN.token && !CMD_IN.dis_tx) begin
			next_st.tx_active = 1'b1;
			next_st.tx_start = 1'b1;
		end
		if (tx_done_q) begin
			next_st.tx_active = 1'b0;
			next_st.ack_live = ENG_IN.tx_acked;
		end
		// New transmit clears live available and ack
		if (CMD_IN.en_tx && (tx_cnt == 2'h0 || (tx_cnt == 2'h1 && st.chain)))
			next_st.ack_live = 1'b0;
		// Live available tracks the queue
		next_st.avail = (tx_cnt == 2'h0 && !CMD_IN.en_tx) ||
			(tx_cnt == 2'h1 && tx_done_q && !CMD_IN.en_tx);
		// Reception begins, ends; inhibit live
		if (rx_busy && ENG_IN.rx_start && !st.rx_active)
			next_st.rx_active = 1'b1;
		if (rx_done_q)
			next_st.rx_active = 1'b0;
		next_st.inhibit = (rx_cnt == 2'h0 && !CMD_IN.en_rx) ||
			(rx_cnt == 2'h1 && rx_done_q && !CMD_IN.en_rx);
		next_st.tx_page = tx_head;
		next_st.rx_page = rx_head;
		next_st.rx_armed = rx_busy;
		next_st.txn = tx_cnt;
		next_st.rxn = rx_cnt;
		// Buffered status shown to host
		next_st.tx_ev = tx_event;
		next_st.tx_ok = tx_event ? tx_ok : 1'b0;
		next_st.rx_ev = rx_event;
		// Ack view registered so the pin comes from a flop
		next_st.ack = next_st.chain ? next_st.tx_ok : next_st.ack_live;
		next_st.irq = irq_line;
	end

	// State register
	always_ff @(posedge CLK_SYS_IN) begin
		if (SRST_IN) begin
			st <= '0;
			st.chain <= `TCQ_CHAIN_RST;
			st.avail <= `TCQ_AVAIL_RST;
			st.inhibit <= `TCQ_INHIBIT_RST;
		end else begin
			st <= next_st;
		end
	end

	assign CHAIN_MODE_OUT = st.chain;
	assign TRANSMITTER_AVAILABLE_FLAG_OUT = st.avail;
	assign RECEIVER_INHIBIT_FLAG_OUT = st.inhibit;
	assign TX_DONE_EVENT_OUT = st.tx_ev;
	assign TX_ACK_FLAG_OUT = st.ack;
	assign RX_DONE_EVENT_OUT = st.rx_ev;
	assign TX_START_OUT = st.tx_start;
	assign TX_PAGE_OUT = st.tx_page;
	assign RX_ARMED_OUT = st.rx_armed;
	assign RX_PAGE_OUT = st.rx_page;
	assign TX_PENDING_OUT = st.txn;
	assign RX_PENDING_OUT = st.rxn;
	assign IRQ_OUT = st.irq;
endmodule

/* testbench/tcq_checker.sv */
`timescale 1ns/100ps
module tcq_checker
	import tcq_pkg::*;
(
	input wire logic CLK_SYS_IN,
	input wire logic SRST_IN,
	input wire logic CHAIN_EN_IN,
	input wire logic TX_AVAIL_MASK_IN,
	input wire logic RX_INHIBIT_MASK_IN,
	input wire tcq_cmd_s CMD_IN,
	input wire tcq_eng_s ENG_IN,
	input wire logic CHAIN_MODE_OUT,
	input wire logic TRANSMITTER_AVAILABLE_FLAG_OUT,
	input wire logic TX_DONE_EVENT_OUT,
	input wire logic RX_DONE_EVENT_OUT,
	input wire logic TX_START_OUT,
	input wire logic [1:0] TX_PENDING_OUT,
	input wire logic [1:0] RX_PENDING_OUT,
	input wire logic IRQ_OUT
);
	logic clr;
	logic msk_on;
	default clocking cb @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (SRST_IN);
	// Helpers for clear commands and interrupt masks
	assign clr = CMD_IN.clr_tx_int | CMD_IN.clr_rx_int;
	assign msk_on = TX_AVAIL_MASK_IN & RX_INHIBIT_MASK_IN;
	AST_CHAIN_NEEDS_EN:
		assert property (CHAIN_MODE_OUT |-> $past(CHAIN_EN_IN) ||
			$past(CHAIN_EN_IN, 2)) else $error("chain without enable");
	AST_TX_EVT_CLR:
		assert property ($fell(TX_DONE_EVENT_OUT) |-> $past(CMD_IN.clr_tx_int)
			|| $past(CMD_IN.clr_tx_int, 2)) else $error("tx event lost");
	AST_RX_EVT_CLR:
		assert property ($fell(RX_DONE_EVENT_OUT) |-> $past(CMD_IN.clr_rx_int)
			|| $past(CMD_IN.clr_rx_int, 2)) else $error("rx event lost");
	AST_IRQ_GAP:
		assert property ($fell(IRQ_OUT) |-> !IRQ_OUT ##1 !IRQ_OUT)
			else $error("irq gap too short");
	AST_IRQ_HELD:
		assert property ($fell(IRQ_OUT) |-> $past(clr) || $past(clr, 2) ||
			!$past(msk_on)) else $error("irq dropped uncleared");
	AST_IRQ_CAUSE:
		assert property ($rose(IRQ_OUT) && CHAIN_MODE_OUT |->
			TX_DONE_EVENT_OUT || RX_DONE_EVENT_OUT) else $error("irq no event");
	AST_FIRST_TX_AVAIL:
		assert property (CMD_IN.en_tx && CHAIN_MODE_OUT && TX_PENDING_OUT ==
			2'h0 |-> ##2 !TRANSMITTER_AVAILABLE_FLAG_OUT) else $error("avail");
	AST_START_ON_TOKEN:
		assert property (TX_START_OUT |-> $past(ENG_IN.token))
			else $error("start without token");
	AST_DEPTH:
		assert property (TX_PENDING_OUT != 2'h3 && RX_PENDING_OUT != 2'h3)
			else $error("queue overfilled");
	// Main scenarios reached
	cover property (TX_PENDING_OUT == 2'h2);
	cover property (RX_PENDING_OUT == 2'h2);
	cover property ($rose(IRQ_OUT) && TX_DONE_EVENT_OUT);
endmodule
bind tcq_top tcq_checker chk (.*);

/* testbench/tcq_eng_model.sv */
`timescale 1ns/100ps
module tcq_eng_model
	import tcq_pkg::*;
(
	input wire logic clk_in,
	input wire logic tok_en_in,
	input wire logic nak_in,
	input wire logic rx_go_in,
	input wire logic tx_start_in,
	input wire logic rx_armed_in,
	output tcq_eng_s eng_out
);
	logic [1:0] div = 2'h0;
	logic [3:0] txd = 4'h0;
	logic [3:0] rxd = 4'h0;
	initial eng_out = '0;
	// Token every fourth cycle, transfers end three cycles after start
	always @(posedge clk_in) begin
		div <= div + 2'h1;
		txd <= tx_start_in ? 4'h3 : (txd != 4'h0 ? txd - 4'h1 : 4'h0);
		rxd <= rx_go_in && rx_armed_in ? 4'h3 :
			(rxd != 4'h0 ? rxd - 4'h1 : 4'h0);
		// One assignment per edge; ack refused on request
		eng_out <= '{token: tok_en_in && div == 2'h0,
			tx_done: txd == 4'h1,
			tx_acked: txd == 4'h1 && !nak_in,
			rx_start: rx_go_in && rx_armed_in,
			rx_done: rxd == 4'h1};
	end
endmodule

/* testbench/tb.sv */
`timescale 1ns/100ps
module tb
	import tcq_pkg::*;
;
	localparam logic [5:0] ETX = 6'h20, DTX = 6'h10, CTX = 6'h08;
	localparam logic [5:0] ERX = 6'h04, DRX = 6'h02, CRX = 6'h01;
	logic clk = 1'b0, rst = 1'b1, ch = 1'b0, tok = 1'b0, nak = 1'b0;
	logic go = 1'b0, a1;
	logic [1:0] msk = 2'h3, tpn, rpn;
	logic [1:0] mul = 2'h0;
	tcq_cmd_s c = '0;
	tcq_eng_s eng;
	logic mode, avail, inhib, tev, ack, rev, start, armed, irq;
	logic [2:0] tpg, rpg, p1, p2;
	logic [31:0] seed = 32'hCBF5C786;
	int n_fail = 0, compares = 0;
	always #50 clk = ~clk;
	tcq_top uut (.CLK_SYS_IN(clk), .SRST_IN(rst), .CHAIN_EN_IN(ch),
		.CLOCK_MULT_SETTING_IN(mul), .TX_AVAIL_MASK_IN(msk[1]),
		.RX_INHIBIT_MASK_IN(msk[0]), .CMD_IN(c), .ENG_IN(eng),
		.CHAIN_MODE_OUT(mode), .TRANSMITTER_AVAILABLE_FLAG_OUT(avail),
		.RECEIVER_INHIBIT_FLAG_OUT(inhib), .TX_DONE_EVENT_OUT(tev),
		.TX_ACK_FLAG_OUT(ack), .RX_DONE_EVENT_OUT(rev), .TX_START_OUT(start),
		.TX_PAGE_OUT(tpg), .RX_ARMED_OUT(armed), .RX_PAGE_OUT(rpg),
		.TX_PENDING_OUT(tpn), .RX_PENDING_OUT(rpn), .IRQ_OUT(irq));
	tcq_eng_model eng_m (.clk_in(clk), .tok_en_in(tok), .nak_in(nak),
		.rx_go_in(go), .tx_start_in(start), .rx_armed_in(armed),
		.eng_out(eng));
	// Random source and expected queue depth
	function logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function logic [1:0] qcnt(input int n, input logic chain);
		return chain ? (n > 2 ? 2'h2 : 2'(n)) : (n > 0 ? 2'h1 : 2'h0);
	endfunction
	task report_and_stop;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task chk(input logic [3:0] g, input logic [3:0] e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task issue(input logic [5:0] v, input logic [2:0] p);
		c = {v, p};
		@(negedge clk);
	endtask
	// Bounded wait on irq (k=0) or tx event (k=1)
	task wsig(input int k, input logic l);
		int i;
		for (i = 0; i < 80 && (k ? tev : irq) !== l; i++) @(negedge clk);
		if ((k ? tev : irq) !== l) begin
			n_fail++;
			report_and_stop;
		end
	endtask
	// Main sequence
	initial begin
		repeat (12) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk({avail, inhib, tev, irq}, 4'hC);
		issue(ETX, 3'h1);
		issue(ETX, 3'h2);
		c = '0;
		repeat (3) @(negedge clk);
		chk({mode, 1'b0, tpn}, {2'h0, qcnt(2, 1'b0)});
		rst = 1'b1;
		ch = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		seed = xs(seed);
		p1 = seed[2:0];
		p2 = seed[6:4];
		a1 = seed[8];
		issue(ETX, p1);
		issue(ETX, p2);
		issue(ETX, ~p1);
		c = '0;
		repeat (3) @(negedge clk);
		chk({tpn, avail, mode}, {qcnt(3, 1'b1), 2'h1});
		chk({1'b0, tpg}, {1'b0, p1});
		nak = !a1;
		tok = 1'b1;
		wsig(0, 1'b1);
		chk({tev, ack, irq, 1'b0}, {1'b1, a1, 2'h2});
		nak = a1;
		issue(DRX, 3'h0);
		issue(CRX, 3'h0);
		c = '0;
		repeat (2) @(negedge clk);
		chk({irq, 3'h0}, 4'h8);
		repeat (28) @(negedge clk);
		chk({tev, ack, irq, avail}, {1'b1, a1, 2'h3});
		tok = 1'b0;
		issue(CTX, 3'h0);
		c = '0;
		wsig(0, 1'b0);
		wsig(0, 1'b1);
		chk({tev, ack, tpn}, {1'b1, !a1, 2'h0});
		issue(CTX, 3'h0);
		c = '0;
		repeat (3) @(negedge clk);
		chk({tev, irq, 2'h0}, 4'h0);
		issue(ETX, p2);
		issue(ETX, p1);
		issue(DTX, 3'h0);
		c = '0;
		repeat (3) @(negedge clk);
		chk({tpn, 1'b0, tpg[0]}, {2'h1, 1'b0, p1[0]});
		issue(DTX, 3'h0);
		c = '0;
		repeat (3) @(negedge clk);
		chk({tpn, avail, 1'b0}, 4'h2);
		msk[1] = 1'b0;
		issue(ETX, p1);
		c = '0;
		tok = 1'b1;
		wsig(1, 1'b1);
		repeat (4) @(negedge clk);
		chk({tev, irq, 2'h0}, 4'h8);
		tok = 1'b0;
		issue(CTX, 3'h0);
		c = '0;
		repeat (3) @(negedge clk);
		msk[1] = 1'b1;
		mul = 2'h1;
		issue(ERX, p1);
		issue(ERX, p2);
		c = '0;
		repeat (3) @(negedge clk);
		chk({rpn, inhib, 1'b0}, {qcnt(2, 1'b1), 2'h0});
		chk({1'b0, rpg}, {1'b0, p1});
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
		wsig(0, 1'b1);
		chk({rev, 3'h0}, 4'h8);
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
		repeat (10) @(negedge clk);
		issue(CRX, 3'h0);
		c = '0;
		wsig(0, 1'b0);
		wsig(0, 1'b1);
		chk({rev, inhib, rpn}, 4'hC);
		issue(CRX, 3'h0);
		c = '0;
		repeat (3) @(negedge clk);
		chk({rev, irq, 2'h0}, 4'h0);
		issue(ERX, p1);
		issue(ERX, p2);
		issue(DRX, 3'h0);
		issue(DRX, 3'h0);
		c = '0;
		repeat (3) @(negedge clk);
		chk({rpn, inhib, 1'b0}, 4'h2);
		report_and_stop;
	end
endmodule
